//--- shared/katr_pkg.sv
// Purpose: Shared constants for the backplane AN / training register bank
// Assumes: 32-bit AHB-Lite, one word per register, byte address = 4 * index
// Notes: Offsets below are register indexes, not byte addresses
package katr_pkg;

   // Register indexes (byte address is index times four)
   localparam logic [9:0] IDX_BASE_UPPER = 10'h0c8;
   localparam logic [9:0] IDX_NEXT_LOWER = 10'h0c9;
   localparam logic [9:0] IDX_NEXT_UPPER = 10'h0ca;
   localparam logic [9:0] IDX_ABILITIES = 10'h0cb;
   localparam logic [9:0] IDX_TRAIN_CTRL = 10'h0d0;
   localparam logic [9:0] IDX_TRAIN_CMD = 10'h0d1;
   localparam logic [9:0] IDX_COEF_VALUE = 10'h0d4;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h0e0;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h0e1;

   // Training control field positions
   localparam int CTL_ENABLE = 0;
   localparam int CTL_NO_MAX_WAIT = 1;
   localparam int CTL_QUICK = 2;
   localparam int CTL_PASS_ONE = 3;
   localparam int CTL_MAIN_LO = 4;
   localparam int CTL_PRPO_LO = 8;
   localparam int CTL_HYST_LO = 12;
   localparam int CTL_KEEP_PMA = 15;
   localparam int CTL_COEF_OVR = 16;
   localparam int CTL_WIDTH = 17;

   // Reset value: enable, pass_one, main 2, pre/post 1, hysteresis 010
   localparam logic [CTL_WIDTH-1:0] CTL_RESET = 17'h02129;

   // Strobe bit in the command register, value field width
   localparam int CMD_COEF_NEW = 4;
   localparam int COEF_WIDTH = 8;

   // Ability register field positions
   localparam int ABL_FEC_LO = 25;
   localparam int ABL_FAULT = 27;
   localparam int ABL_PAUSE_LO = 28;

   // Interrupt status bits
   localparam int IRQ_BASE_PAGE = 0;
   localparam int IRQ_NEXT_PAGE = 1;
   localparam int IRQ_TRAIN_FAIL = 2;
   localparam int IRQ_WIDTH = 3;

   // AHB transfer type bit, set for both NONSEQ and SEQ
   localparam int HTRANS_ACTIVE = 1;

   // Bus phase tracker, one-hot
   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_WRITE = 4'b0010,
      PH_RD_WAIT = 4'b0100,
      PH_RD_DONE = 4'b1000
   } katr_phase_e;

endpackage

//--- src/katr_regs.sv
// Purpose: AHB-Lite register bank holding received AN pages and training control
// Assumes: AN receive and training state machines sit outside and use the ports
// Notes: Writes complete with no wait; reads insert one wait state
//
// What this block does
// [R1] Received base page captured, hardware updated only
// [R2] Base upper: tech [29:5], nonce [4:0]
// [R3] Next lower: NP, ACK, MP, SECOND_ACKNOWLEDGE, toggle
// [R4] Next upper bits 31:0 hold page 47:16
// [R5] Technology field bits 24:0 from partner
// [R6] FEC request bit 26, ability bit 25
// [R7] Partner remote fault in bit 27
// [R8] Pause bits 30:28 from D11:D10
// [R9] Control bit 0 enables training, resets 1
// [R10] Control bit 1 disables max-wait timeout
// [R11] Control bit 2 selects quick search
// [R12] Control bit 3 continues past minimum, resets 1
// [R13] Bits 7:4 main tap steps, reset 2
// [R14] Bits 11:8 pre/post steps, reset 1
// [R15] Bits 14:12 hysteresis code, reset 010
// [R16] Timeout enters failure; bit 15 keeps PMA
// [R17] Bit 16 hands coefficient commands to software
// [R18] New-coefficient strobe only honoured with override
// [R19] Writes to read-only registers ignored
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module katr_regs
   import katr_pkg::*;
(
   input wire logic hclk, // Bus clock, 100 MHz
   input wire logic hresetn, // Asynchronous reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   output logic [31:0] hrdata, // Read data
   input wire logic an_base_valid, // Base page received pulse
   input wire logic an_next_valid, // Next page received pulse
   input wire logic [47:0] an_rx_page, // Received page bits 47:0
   input wire logic lt_max_wait_done, // Max-wait timer expired pulse
   output logic lt_enable, // Training protocol enabled
   output logic lt_max_wait_enable, // Max-wait timer in force
   output logic lt_quick_mode, // Only init and preset tried
   output logic lt_pass_one, // Search beyond first minimum
   output logic [3:0] lt_main_steps, // Steps per main tap update
   output logic [3:0] lt_prpo_steps, // Steps per pre/post update
   output logic [4:0] lt_hysteresis, // Decoded error-count hysteresis
   output logic lt_failed, // Training in failure state
   output logic lt_pma_reinit, // Reinitialise PMA pulse
   output logic lt_auto_coef, // Generate partner commands
   output logic [COEF_WIDTH-1:0] lt_coef_cmd, // Software coefficient command
   output logic lt_coef_new, // Send software command pulse
   output logic irq // Level interrupt
);

   typedef struct packed {
      katr_phase_e phase;
      logic [9:0] idx;
      logic [31:0] base_upper;
      logic [15:0] next_lower;
      logic [31:0] next_upper;
      logic [31:0] abilities;
      logic [CTL_WIDTH-1:0] ctrl;
      logic [COEF_WIDTH-1:0] coef;
      logic coef_new;
      logic failed;
      logic pma_reinit;
      logic [IRQ_WIDTH-1:0] status;
      logic [IRQ_WIDTH-1:0] mask;
      logic [31:0] rdata;
   } katr_state_s;

   katr_state_s st_reg;
   katr_state_s st_next;

   // Hysteresis code to error-count amount; unlisted codes give none
   function automatic logic [4:0] hyst_decode(input logic [2:0] code);
      logic [4:0] v;
      v = 5'h00;
      // Code 101 is listed twice upstream; the 8 entry is kept
      case (code)
         3'h1: v = 5'h01;
         3'h2: v = 5'h02;
         3'h4: v = 5'h04;
         3'h5: v = 5'h08;
         default: v = 5'h00;
      endcase
      return v;
   endfunction

   // Read multiplexer; unmapped indexes read as zero
   function automatic logic [31:0] read_mux(input katr_state_s s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (s.idx)
         IDX_BASE_UPPER:
         begin
            v = s.base_upper; // [R2]
         end
         IDX_NEXT_LOWER:
         begin
            v = {16'h0000, s.next_lower}; // [R3]
         end
         IDX_NEXT_UPPER:
         begin
            v = s.next_upper; // [R4]
         end
         IDX_ABILITIES:
         begin
            v = s.abilities; // [R5]
         end
         IDX_TRAIN_CTRL:
         begin
            v = {15'h0000, s.ctrl};
         end
         IDX_TRAIN_CMD:
         begin
            v = 32'h0000_0000; // Strobes read back as zero
         end
         IDX_COEF_VALUE:
         begin
            v = {24'h00_0000, s.coef};
         end
         IDX_IRQ_STATUS:
         begin
            v = {29'h0000_0000, s.status};
         end
         IDX_IRQ_MASK:
         begin
            v = {29'h0000_0000, s.mask};
         end
         default:
         begin
            v = 32'h0000_0000;
         end
      endcase
      return v;
   endfunction

   logic take;
   logic wr_now;
   logic [IRQ_WIDTH-1:0] events;
   logic fail_entry;

   // Address phase accepted when selected, an active transfer type, and the bus is ready
   assign take = hsel && hready && htrans[HTRANS_ACTIVE];
   assign wr_now = (st_reg.phase == PH_WRITE);
   // Timeout only counts while training runs and the timer is not disabled
   assign fail_entry = lt_max_wait_done && st_reg.ctrl[CTL_ENABLE]
      && !st_reg.ctrl[CTL_NO_MAX_WAIT] && !st_reg.failed; // [R10] [R16]
   assign events = {fail_entry, an_next_valid, an_base_valid};

   // Next-state logic for bus phase, registers and training side effects
   always_comb
   begin
      st_next = st_reg;
      st_next.coef_new = 1'b0;
      st_next.pma_reinit = 1'b0;

      // Bus phase tracking
      case (st_reg.phase)
         PH_IDLE, PH_WRITE, PH_RD_DONE:
         begin
            // New address phase taken in idle or any closing data phase
            if (take)
            begin
               st_next.idx = haddr[11:2];
               st_next.phase = hwrite ? PH_WRITE : PH_RD_WAIT;
            end
            else
            begin
               st_next.phase = PH_IDLE;
            end
         end
         PH_RD_WAIT:
         begin
            // Extra cycle lets a write in the prior data phase land first
            st_next.rdata = read_mux(st_reg);
            st_next.phase = PH_RD_DONE;
         end
         default:
         begin
            st_next.phase = PH_IDLE;
         end
      endcase

      // Pages come only from the receive state machine
      if (an_base_valid)
      begin
         st_next.base_upper = {2'b00, an_rx_page[45:21], an_rx_page[20:16]}; // [R1] [R2]
         // Base page also feeds the decoded abilities
         st_next.abilities[24:0] = an_rx_page[45:21]; // [R5]
         st_next.abilities[ABL_FEC_LO+1] = an_rx_page[47]; // [R6]
         st_next.abilities[ABL_FEC_LO] = an_rx_page[46]; // [R6]
         st_next.abilities[ABL_FAULT] = an_rx_page[13]; // [R7]
         st_next.abilities[ABL_PAUSE_LO+2 -: 3] = {1'b0, an_rx_page[11:10]}; // [R8]
         // Reserved top bit reads zero
         st_next.abilities[31] = 1'b0;
      end
      if (an_next_valid)
      begin
         // Lower word keeps every page bit 15:0, not only the flags
         st_next.next_lower = an_rx_page[15:0]; // [R3]
         st_next.next_upper = an_rx_page[47:16]; // [R4]
      end

      // Register writes; read-only indexes fall through untouched
      if (wr_now)
      begin
         case (st_reg.idx)
            IDX_TRAIN_CTRL:
            begin
               // Whole control word; upper bus bits have no storage
               st_next.ctrl = hwdata[CTL_WIDTH-1:0]; // [R9] [R13] [R14] [R15]
            end
            IDX_TRAIN_CMD:
            begin
               // Software strobe is dropped unless override is on
               st_next.coef_new = hwdata[CMD_COEF_NEW] && st_reg.ctrl[CTL_COEF_OVR]; // [R18]
            end
            IDX_COEF_VALUE:
            begin
               // Command value waits here until the strobe sends it
               st_next.coef = hwdata[COEF_WIDTH-1:0]; // [R17]
            end
            IDX_IRQ_MASK:
            begin
               // Mask bits line up with the status bits
               st_next.mask = hwdata[IRQ_WIDTH-1:0];
            end
            IDX_IRQ_STATUS:
            begin
               // Write one to clear; zeros leave bits alone
               st_next.status = st_reg.status & ~hwdata[IRQ_WIDTH-1:0];
            end
            IDX_BASE_UPPER, IDX_NEXT_LOWER, IDX_NEXT_UPPER, IDX_ABILITIES:
            begin
               // Partner pages belong to the receive side only
               st_next.status = st_next.status; // [R19]
            end
            default:
            begin
               // Unmapped index: write is dropped
               st_next.status = st_next.status;
            end
         endcase
      end

      // New events win over a clear in the same cycle
      st_next.status = st_next.status | events;

      // Failure state entry; PMA reinit unless software asked to keep it
      if (fail_entry)
      begin
         st_next.failed = 1'b1; // [R16]
         st_next.pma_reinit = !st_reg.ctrl[CTL_KEEP_PMA]; // [R16]
      end
      else if (!st_next.ctrl[CTL_ENABLE])
      begin
         st_next.failed = 1'b0; // Disabling training leaves failure
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_reg <= '{phase: PH_IDLE, ctrl: CTL_RESET, default: '0}; // [R9] [R12] [R13] [R14] [R15]
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Bus answers: only the read wait phase stalls
   assign hreadyout = (st_reg.phase != PH_RD_WAIT);
   assign hresp = 1'b0;
   assign hrdata = st_reg.rdata;

   // Training run and timer switches
   assign lt_enable = st_reg.ctrl[CTL_ENABLE]; // [R9]
   assign lt_max_wait_enable = !st_reg.ctrl[CTL_NO_MAX_WAIT]; // [R10]

   // Search options for the error-rate walk
   assign lt_quick_mode = st_reg.ctrl[CTL_QUICK]; // [R11]
   assign lt_pass_one = st_reg.ctrl[CTL_PASS_ONE]; // [R12]

   // Step sizes; a zero step is stored as written, software must avoid it
   assign lt_main_steps = st_reg.ctrl[CTL_MAIN_LO +: 4]; // [R13]
   assign lt_prpo_steps = st_reg.ctrl[CTL_PRPO_LO +: 4]; // [R14]

   // Hysteresis leaves decoded so the trainer needs no table
   assign lt_hysteresis = hyst_decode(st_reg.ctrl[CTL_HYST_LO +: 3]); // [R15]

   // Failure state and its one-cycle reinit request
   assign lt_failed = st_reg.failed;
   assign lt_pma_reinit = st_reg.pma_reinit;

   // Coefficient hand-off to software when override is set
   assign lt_auto_coef = !st_reg.ctrl[CTL_COEF_OVR]; // [R17]
   assign lt_coef_cmd = st_reg.coef;
   assign lt_coef_new = st_reg.coef_new;

   // Interrupt level follows unmasked sticky status
   assign irq = |(st_reg.status & st_reg.mask);

endmodule
`default_nettype wire

//--- bench/katr_regs_monitor.sv
// Purpose: Port-level checks on the AN/training register bank
// Assumes: Single slave, hready equals hreadyout
// Notes: Bound to the top module after the module body
`timescale 1ns/100ps
`default_nettype none
module katr_regs_monitor (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset, low
   input wire logic hsel, // Select
   input wire logic [1:0] htrans, // Type
   input wire logic hwrite, // Write
   input wire logic hready, // Bus ready
   input wire logic hreadyout, // Slave ready
   input wire logic lt_max_wait_done, // Expiry
   input wire logic lt_enable, // Training on
   input wire logic lt_max_wait_enable, // Timer on
   input wire logic lt_failed, // Failed
   input wire logic lt_pma_reinit, // Reinit pulse
   input wire logic lt_auto_coef, // Auto commands
   input wire logic lt_coef_new, // Command pulse
   input wire logic [4:0] lt_hysteresis // Hysteresis
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Qualified timeout and bus requests
   logic arm;
   logic req;
   assign arm = lt_max_wait_done && lt_enable && lt_max_wait_enable;
   assign req = hsel && hready && htrans[1];
   // Reads cost one wait state, writes none
   read_wait_a: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (req && hwrite |=> hreadyout)
      else $error("write stalled");
   fail_entry_a: assert property (arm && !lt_failed |=> lt_failed)
      else $error("timeout missed");
   fail_cause_a: assert property (!lt_failed && !arm |=> !lt_failed)
      else $error("failure without timeout");
   fail_hold_a: assert property (lt_failed |=> lt_failed || !lt_enable)
      else $error("failure dropped");
   reinit_pulse_a: assert property (lt_pma_reinit |-> $rose(lt_failed) ##1 !lt_pma_reinit)
      else $error("reinit pulse wrong");
   coef_gate_a: assert property (lt_coef_new |-> !lt_auto_coef)
      else $error("strobe without override");
   hyst_code_a: assert property (lt_hysteresis inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08})
      else $error("bad hysteresis");
   // Main scenarios reached
   cover property ($rose(lt_failed));
   cover property (lt_coef_new);
   cover property (req && !hwrite);
endmodule
bind katr_regs katr_regs_monitor mon_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .lt_max_wait_done, .lt_enable, .lt_max_wait_enable, .lt_failed,
   .lt_pma_reinit, .lt_auto_coef, .lt_coef_new, .lt_hysteresis);
`default_nettype wire

//--- bench/katr_partner.sv
// Purpose: AN receiver and training timer model
// Assumes: Pulses last one clock
// Notes: Page lines are not held after a pulse
`timescale 1ns/100ps
`default_nettype none
module katr_partner (
   input wire logic hclk, // Clock
   output logic an_base_valid, // Base pulse
   output logic an_next_valid, // Next pulse
   output logic [47:0] an_rx_page, // Page
   output logic lt_max_wait_done // Expiry pulse
);
   initial
   begin
      an_base_valid = 1'b0;
      an_next_valid = 1'b0;
      an_rx_page = 48'h0;
      lt_max_wait_done = 1'b0;
   end
   // Page then its inverse, so a late capture is seen
   task automatic send(input logic base, input logic [47:0] p);
      @(posedge hclk);
      an_base_valid <= base;
      an_next_valid <= !base;
      an_rx_page <= p;
      @(posedge hclk);
      an_base_valid <= 1'b0;
      an_next_valid <= 1'b0;
      an_rx_page <= ~p;
   endtask
   task automatic expire();
      @(posedge hclk);
      lt_max_wait_done <= 1'b1;
      @(posedge hclk);
      lt_max_wait_done <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- bench/kr_autoneg_training_regs_bench.sv
// Purpose: Self-checking bench for the AN/training register bank
// Assumes: Partner model drives pages and expiry
// Notes: Byte address is four times the index
`timescale 1ns/100ps
`default_nettype none
module kr_autoneg_training_regs_bench
   import katr_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hready, hreadyout, hresp, irq, bv, nv, wd, en, mwe, qm, po, fl, ri, ac, cn;
   logic [3:0] ms, ps;
   logic [4:0] hy;
   logic [7:0] cc;
   logic [47:0] pg;
   int fails = 0, total_checks = 0;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   katr_regs dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .an_base_valid(bv), .an_next_valid(nv),
      .an_rx_page(pg), .lt_max_wait_done(wd), .lt_enable(en), .lt_max_wait_enable(mwe),
      .lt_quick_mode(qm), .lt_pass_one(po), .lt_main_steps(ms), .lt_prpo_steps(ps),
      .lt_hysteresis(hy), .lt_failed(fl), .lt_pma_reinit(ri), .lt_auto_coef(ac),
      .lt_coef_cmd(cc), .lt_coef_new(cn), .irq);
   katr_partner p_u (.hclk, .an_base_valid(bv), .an_next_valid(nv), .an_rx_page(pg),
      .lt_max_wait_done(wd));
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Address phase held until ready, then data phase until ready
   task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, i, 2'h0};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask
   task automatic rd(input logic [9:0] i, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, i, 32'h0, q);
      check($sformatf("reg %h", i), q, e);
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Pages, read-only writes ignored, interrupt raise/mask/clear
   task automatic t_pages();
      logic [47:0] p;
      logic [47:0] n;
      p = 48'hc123_4567_2400;
      n = 48'h9abc_def0_a800;
      p_u.send(1'b1, p);
      wr(IDX_BASE_UPPER, 32'hffff_ffff);
      rd(IDX_BASE_UPPER, {2'h0, p[45:21], p[20:16]});
      p_u.send(1'b0, n);
      rd(IDX_ABILITIES, {2'h0, p[11], p[10], p[13], p[47], p[46], p[45:21]});
      rd(IDX_NEXT_LOWER, {16'h0, n[15:0]});
      rd(IDX_NEXT_UPPER, n[47:16]);
      rd(IDX_IRQ_STATUS, 32'h3);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(IDX_IRQ_MASK, 32'h1);
      #1 check("irq on", {31'h0, irq}, 32'h1);
      @(posedge hclk);
      wr(IDX_IRQ_STATUS, 32'h1);
      #1 check("irq off", {31'h0, irq}, 32'h0);
      @(posedge hclk);
      rd(IDX_IRQ_STATUS, 32'h2);
      wr(IDX_IRQ_STATUS, 32'h2);
      rd(10'h0ff, 32'h0);
      $display("pages done");
   endtask
   // Control word fields and hysteresis codes
   task automatic t_ctrl();
      logic [4:0] hx [8] = '{5'h00, 5'h01, 5'h02, 5'h00, 5'h04, 5'h08, 5'h00, 5'h00};
      for (int c = 0; c < 8; c++)
      begin
         wr(IDX_TRAIN_CTRL, 32'h0001_0f07 | (32'(c) << 12));
         #1 check("pins", {en, mwe, qm, po, ms, ps, ac, hy},
            {4'b1010, 4'h0, 4'hf, 1'b0, hx[c]});
         @(posedge hclk);
      end
      wr(IDX_TRAIN_CTRL, 32'hffff_ffff);
      rd(IDX_TRAIN_CTRL, 32'h0001_ffff);
      $display("control done");
   endtask
   // Timeout with reinit, kept PMA, and timer disabled
   task automatic t_fail();
      logic [31:0] cv [3] = '{32'h2129, 32'ha129, 32'h212b};
      logic [1:0] ex [3] = '{2'h3, 2'h2, 2'h0};
      for (int k = 0; k < 3; k++)
      begin
         wr(IDX_TRAIN_CTRL, 32'h0);
         wr(IDX_TRAIN_CTRL, cv[k]);
         p_u.expire();
         #1 check("fail", {30'h0, fl, ri}, {30'h0, ex[k]});
         @(posedge hclk);
      end
      rd(IDX_IRQ_STATUS, 32'h4);
      $display("failure done");
   endtask
   // Software coefficient strobe with and without override
   task automatic t_coef();
      wr(IDX_COEF_VALUE, 32'h5a);
      for (int k = 0; k < 2; k++)
      begin
         wr(IDX_TRAIN_CTRL, 32'h2129 | (32'(k) << 16));
         wr(IDX_TRAIN_CMD, 32'h10);
         #1 check("coef", {23'h0, cn, cc}, {23'h0, 1'(k), 8'h5a});
         @(posedge hclk);
      end
      rd(IDX_TRAIN_CMD, 32'h0);
      $display("coef done");
   endtask
   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1 check("reset", {en, mwe, qm, po, ms, ps, ac, hy},
         {4'b1101, 4'h2, 4'h1, 1'b1, 5'h02});
      @(posedge hclk);
      rd(IDX_TRAIN_CTRL, 32'h2129);
      t_pages();
      t_ctrl();
      t_fail();
      t_coef();
      end_of_test();
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge hclk);
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
